/* File: hw/scb_pkg.sv */
package scb_pkg;

  // ************************************************************
  // frame geometry
  // ************************************************************
  localparam int unsigned SCB_ADDR_W = 13;
  localparam int unsigned SCB_NUM_CH = 2;
  localparam int unsigned SCB_NUM_SHADOW = 13;
  localparam logic [3:0] SCB_INSTR_LAST = 4'hF;
  localparam logic [3:0] SCB_BYTE_LAST = 4'h7;
  localparam int unsigned SCB_INSTR_RW = 15;
  localparam int unsigned SCB_INSTR_LEN_LSB = 13;
  localparam logic [1:0] SCB_LEN_STREAM = 2'h3;
  localparam logic [2:0] SCB_STRAP_SETTLE = 3'h4;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [12:0] SCB_ADDR_PORT_CFG = 13'h0000;
  localparam logic [12:0] SCB_ADDR_CHIP_ID = 13'h0001;
  localparam logic [12:0] SCB_ADDR_GRADE = 13'h0002;
  localparam logic [12:0] SCB_ADDR_CHAN_SEL = 13'h0005;
  localparam logic [12:0] SCB_ADDR_POWER = 13'h0008;
  localparam logic [12:0] SCB_ADDR_CLOCK = 13'h0009;
  localparam logic [12:0] SCB_ADDR_SHD_0D = 13'h000D;
  localparam logic [12:0] SCB_ADDR_SHD_10 = 13'h0010;
  localparam logic [12:0] SCB_ADDR_OUT_MODE = 13'h0014;
  localparam logic [12:0] SCB_ADDR_SHD_30 = 13'h0030;
  localparam logic [12:0] SCB_ADDR_FD_FIRST = 13'h0045;
  localparam logic [12:0] SCB_ADDR_FD_LAST = 13'h004C;
  localparam logic [12:0] SCB_ADDR_COMMIT = 13'h00FF;

  // ************************************************************
  // reset values and fields
  // ************************************************************
  localparam logic [7:0] SCB_RST_PORT_CFG = 8'h18;
  localparam logic [7:0] SCB_PORT_CFG_SOFT_RST = 8'h24;
  localparam logic [7:0] SCB_RST_GRADE = 8'h00;
  localparam logic [1:0] SCB_RST_CHAN_SEL = 2'h3;
  localparam logic [7:0] SCB_RST_CLOCK = 8'h01;
  localparam logic [7:0] SCB_RST_POWER = 8'h80;
  localparam logic [7:0] SCB_RST_OUT_MODE = 8'h01;
  localparam logic [7:0] SCB_RST_SHADOW = 8'h00;
  localparam logic SCB_RST_STRAP_STAB = 1'b1;
  localparam logic SCB_RST_STRAP_TWOS = 1'b0;
  localparam int unsigned SCB_BIT_STAB = 0;
  localparam int unsigned SCB_BIT_COMMIT = 0;
  localparam int unsigned SCB_BIT_CH_A = 0;
  localparam int unsigned SCB_BIT_CH_B = 1;
  localparam int unsigned SCB_BIT_TWOS = 0;
  localparam int unsigned SCB_BIT_FD_EN = 0;
  localparam int unsigned SCB_BIT_EXT_PD = 5;
  localparam logic [3:0] SCB_IDX_POWER = 4'h0;
  localparam logic [3:0] SCB_IDX_OUT_MODE = 4'h3;
  localparam logic [3:0] SCB_IDX_FD_FIRST = 4'h5;

  typedef enum logic [1:0] {SCB_IDLE, SCB_INSTR, SCB_DATA, SCB_DONE} scb_state_t;

  typedef struct packed {
    logic fd_enable;
    logic ext_pd_standby;
    logic [1:0] power_mode;
  } scb_ch_cfg_t;

  typedef struct packed {
    logic [12:0] addr;
    logic [7:0] data;
  } scb_wr_t;

  // hit flag in bit 4, slot index below
  function automatic logic [4:0] scb_shadow_slot(input logic [12:0] a);
    logic [12:0] off;
    off = a - SCB_ADDR_FD_FIRST;
    if (a == SCB_ADDR_POWER) scb_shadow_slot = {1'b1, SCB_IDX_POWER};
    else if (a == SCB_ADDR_SHD_0D) scb_shadow_slot = {1'b1, 4'h1};
    else if (a == SCB_ADDR_SHD_10) scb_shadow_slot = {1'b1, 4'h2};
    else if (a == SCB_ADDR_OUT_MODE) scb_shadow_slot = {1'b1, SCB_IDX_OUT_MODE};
    else if (a == SCB_ADDR_SHD_30) scb_shadow_slot = {1'b1, 4'h4};
    else if (a >= SCB_ADDR_FD_FIRST && a <= SCB_ADDR_FD_LAST) begin
      scb_shadow_slot = {1'b1, SCB_IDX_FD_FIRST + off[3:0]};
    end else scb_shadow_slot = 5'h00;
  endfunction

  function automatic logic [7:0] scb_shadow_rst(input logic [3:0] idx);
    if (idx == SCB_IDX_POWER) scb_shadow_rst = SCB_RST_POWER;
    else if (idx == SCB_IDX_OUT_MODE) scb_shadow_rst = SCB_RST_OUT_MODE;
    else scb_shadow_rst = SCB_RST_SHADOW;
  endfunction

endpackage

/* File: hw/scb_sync.sv */
`timescale 1ns/1ps
module scb_sync #(
  parameter int unsigned WIDTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // ************************************************************
  // two-stage synchroniser, first stage read only by second
  // ************************************************************
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

/* File: hw/scb_spi_config_bank.sv */
`timescale 1ns/1ps
module scb_spi_config_bank
  import scb_pkg::*;
#(
  parameter logic [7:0] CHIP_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] CHIP_GRADE = SCB_RST_GRADE
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic SCLK,
  input wire logic CHIP_SELECT_N,
  input wire logic SDIO_IN,
  output logic SDIO_OUT,
  output logic SDIO_OE_N,
  output logic STRAP_MODE,
  output logic DUTY_CYCLE_STABILIZER,
  output logic TWOS_COMPLEMENT,
  output scb_ch_cfg_t CHA_CFG,
  output scb_ch_cfg_t CHB_CFG
);

  // ************************************************************
  // pin synchronisation and edges
  // ************************************************************
  logic [2:0] pins_s;
  logic sclk_s, csn_s, sdio_s;
  logic sclk_prev_q, csn_prev_q;
  logic sclk_rise, sclk_fall, csn_fall;

  scb_sync #(
    .WIDTH(3),
    .RST_VAL(3'h2)
  ) u_sync (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .d({SCLK, CHIP_SELECT_N, SDIO_IN}),
    .q(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign csn_s = pins_s[1];
  assign sdio_s = pins_s[0];

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sclk_prev_q <= 1'b0;
      csn_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      csn_prev_q <= csn_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_q & ~csn_s;
  assign sclk_fall = ~sclk_s & sclk_prev_q & ~csn_s;
  assign csn_fall = ~csn_s & csn_prev_q;

  // ************************************************************
  // register storage
  // ************************************************************
  logic [7:0] port_cfg_q;
  logic [1:0] chan_sel_q;
  logic [7:0] clock_q;
  logic commit_q;
  logic [7:0] master_q [SCB_NUM_CH][SCB_NUM_SHADOW];
  logic [7:0] active_q [SCB_NUM_CH][SCB_NUM_SHADOW];
  logic wr_valid_q;
  scb_wr_t wr_q;
  logic [4:0] wr_slot;

  assign wr_slot = scb_shadow_slot(wr_q.addr);

  // both selected reads channel A; neither selected also falls back to A
  function automatic logic [7:0] read_byte(input logic [12:0] a);
    logic [4:0] slot;
    logic ch;
    slot = scb_shadow_slot(a);
    ch = ~chan_sel_q[SCB_BIT_CH_A] & chan_sel_q[SCB_BIT_CH_B];
    if (slot[4]) read_byte = master_q[ch][slot[3:0]];
    else if (a == SCB_ADDR_PORT_CFG) read_byte = port_cfg_q;
    else if (a == SCB_ADDR_CHIP_ID) read_byte = CHIP_ID;
    else if (a == SCB_ADDR_GRADE) read_byte = CHIP_GRADE;
    else if (a == SCB_ADDR_CHAN_SEL) read_byte = {6'h00, chan_sel_q};
    else if (a == SCB_ADDR_CLOCK) read_byte = clock_q;
    else if (a == SCB_ADDR_COMMIT) read_byte = {7'h00, commit_q};
    else read_byte = 8'h00;
  endfunction

  // ************************************************************
  // serial frame
  // ************************************************************
  scb_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [15:0] instr_q;
  logic [15:0] instr_d;
  logic [7:0] shift_in_q;
  logic [7:0] shift_in_d;
  logic [7:0] shift_out_q;
  logic rd_q;
  logic [1:0] len_q;
  logic [1:0] byte_cnt_q;
  logic [12:0] addr_q;
  logic instr_end, byte_end;

  assign instr_d = {instr_q[14:0], sdio_s};
  assign shift_in_d = {shift_in_q[6:0], sdio_s};
  assign instr_end = sclk_rise && (state_q == SCB_IDLE || state_q == SCB_INSTR)
                     && bit_cnt_q == SCB_INSTR_LAST;
  assign byte_end = sclk_rise && state_q == SCB_DATA && bit_cnt_q == SCB_BYTE_LAST;

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= SCB_IDLE;
      bit_cnt_q <= 4'h0;
      instr_q <= 16'h0000;
      shift_in_q <= 8'h00;
      rd_q <= 1'b0;
      len_q <= 2'h0;
      byte_cnt_q <= 2'h0;
      addr_q <= 13'h0000;
    end else if (csn_s) begin
      state_q <= SCB_IDLE;
      bit_cnt_q <= 4'h0;
    end else if (sclk_rise) begin
      case (state_q)
        SCB_IDLE, SCB_INSTR: begin
          instr_q <= instr_d;
          bit_cnt_q <= bit_cnt_q + 4'h1;
          state_q <= SCB_INSTR;
          if (instr_end) begin
            state_q <= SCB_DATA;
            bit_cnt_q <= 4'h0;
            rd_q <= instr_d[SCB_INSTR_RW];
            len_q <= instr_d[SCB_INSTR_LEN_LSB +: 2];
            byte_cnt_q <= 2'h0;
            addr_q <= instr_d[SCB_ADDR_W-1:0];
          end
        end
        SCB_DATA: begin
          shift_in_q <= shift_in_d;
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (byte_end) begin
            bit_cnt_q <= 4'h0;
            addr_q <= addr_q + 13'h0001;
            byte_cnt_q <= byte_cnt_q + 2'h1;
            if (len_q != SCB_LEN_STREAM && byte_cnt_q == len_q) begin
              state_q <= SCB_DONE;
            end
          end
        end
        default: begin
          state_q <= SCB_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_valid_q <= 1'b0;
      wr_q <= '0;
    end else begin
      wr_valid_q <= byte_end && !rd_q;
      if (byte_end) begin
        wr_q <= '{addr: addr_q, data: shift_in_d};
      end
    end
  end

  // ************************************************************
  // readback drive
  // ************************************************************
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      shift_out_q <= 8'h00;
      SDIO_OUT <= 1'b0;
      SDIO_OE_N <= 1'b1;
    end else begin
      SDIO_OE_N <= !(state_q == SCB_DATA && rd_q && !csn_s);
      if (instr_end) begin
        shift_out_q <= read_byte(instr_d[SCB_ADDR_W-1:0]);
      end else if (byte_end && rd_q) begin
        shift_out_q <= read_byte(addr_q + 13'h0001);
      end else if (sclk_fall && state_q == SCB_DATA && rd_q) begin
        SDIO_OUT <= shift_out_q[7];
        shift_out_q <= {shift_out_q[6:0], 1'b0};
      end
    end
  end

  // ************************************************************
  // global registers
  // ************************************************************
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      port_cfg_q <= SCB_RST_PORT_CFG;
      chan_sel_q <= SCB_RST_CHAN_SEL;
      clock_q <= SCB_RST_CLOCK;
    end else if (wr_valid_q) begin
      // channel select is not consulted here
      if (wr_q.addr == SCB_ADDR_PORT_CFG) begin
        port_cfg_q <= wr_q.data & ~SCB_PORT_CFG_SOFT_RST;
      end else if (wr_q.addr == SCB_ADDR_CHAN_SEL) begin
        chan_sel_q <= wr_q.data[1:0];
      end else if (wr_q.addr == SCB_ADDR_CLOCK) begin
        clock_q <= {7'h00, wr_q.data[SCB_BIT_STAB]};
      end
    end
  end

  // set wins over the self-clear so a back-to-back commit is kept
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      commit_q <= 1'b0;
    end else if (wr_valid_q && wr_q.addr == SCB_ADDR_COMMIT && wr_q.data[SCB_BIT_COMMIT]) begin
      commit_q <= 1'b1;
    end else if (commit_q) begin
      commit_q <= 1'b0;
    end
  end

  // ************************************************************
  // per-channel shadowed registers
  // ************************************************************
  for (genvar g = 0; g < SCB_NUM_CH; g++) begin : g_ch
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        for (int i = 0; i < SCB_NUM_SHADOW; i++) begin
          master_q[g][i] <= scb_shadow_rst(4'(i));
        end
      end else if (wr_valid_q && wr_slot[4] && chan_sel_q[g]) begin
        master_q[g][wr_slot[3:0]] <= wr_q.data;
      end
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        for (int i = 0; i < SCB_NUM_SHADOW; i++) begin
          active_q[g][i] <= scb_shadow_rst(4'(i));
        end
      end else if (commit_q) begin
        for (int i = 0; i < SCB_NUM_SHADOW; i++) begin
          active_q[g][i] <= master_q[g][i];
        end
      end
    end
  end

  // ************************************************************
  // straps
  // ************************************************************
  // an idle-high select cannot be told from a tied one, so the
  // port counts as disabled until the first select falling edge
  logic strap_mode_q;
  logic strap_done_q;
  logic [2:0] strap_cnt_q;
  logic strap_stab_q;
  logic strap_twos_q;

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      strap_mode_q <= 1'b1;
      strap_done_q <= 1'b0;
      strap_cnt_q <= 3'h0;
      strap_stab_q <= SCB_RST_STRAP_STAB;
      strap_twos_q <= SCB_RST_STRAP_TWOS;
    end else begin
      if (csn_fall) begin
        strap_mode_q <= 1'b0;
      end
      if (!strap_done_q) begin
        strap_cnt_q <= strap_cnt_q + 3'h1;
        if (strap_cnt_q == SCB_STRAP_SETTLE) begin
          strap_done_q <= 1'b1;
          strap_stab_q <= sdio_s;
          strap_twos_q <= sclk_s;
        end
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  function automatic scb_ch_cfg_t ch_cfg(input logic [7:0] pwr, input logic [7:0] fd);
    ch_cfg = '{fd_enable: fd[SCB_BIT_FD_EN], ext_pd_standby: pwr[SCB_BIT_EXT_PD],
               power_mode: pwr[1:0]};
  endfunction

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      STRAP_MODE <= 1'b1;
      DUTY_CYCLE_STABILIZER <= SCB_RST_STRAP_STAB;
      TWOS_COMPLEMENT <= SCB_RST_STRAP_TWOS;
      CHA_CFG <= ch_cfg(SCB_RST_POWER, SCB_RST_SHADOW);
      CHB_CFG <= ch_cfg(SCB_RST_POWER, SCB_RST_SHADOW);
    end else begin
      STRAP_MODE <= strap_mode_q;
      if (strap_mode_q) begin
        DUTY_CYCLE_STABILIZER <= strap_stab_q;
        TWOS_COMPLEMENT <= strap_twos_q;
      end else begin
        DUTY_CYCLE_STABILIZER <= clock_q[SCB_BIT_STAB];
        TWOS_COMPLEMENT <= active_q[0][SCB_IDX_OUT_MODE][SCB_BIT_TWOS];
      end
      CHA_CFG <= ch_cfg(active_q[0][SCB_IDX_POWER], active_q[0][SCB_IDX_FD_FIRST]);
      CHB_CFG <= ch_cfg(active_q[1][SCB_IDX_POWER], active_q[1][SCB_IDX_FD_FIRST]);
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  logic wr_pwr;
  assign wr_pwr = wr_valid_q && wr_q.addr == SCB_ADDR_POWER;

  property p_oe_read_only;
    !SDIO_OE_N |-> $past(state_q == SCB_DATA && rd_q && !csn_s);
  endproperty
  a_oe_read_only: assert property (p_oe_read_only) else $error("data pin driven outside read");

  property p_oe_write;
    state_q == SCB_DATA && !rd_q |=> SDIO_OE_N;
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("data pin driven during write");

  property p_commit_clears;
    commit_q && !(wr_valid_q && wr_q.addr == SCB_ADDR_COMMIT) |=> !commit_q;
  endproperty
  a_commit_clears: assert property (p_commit_clears) else $error("commit bit stuck");

  property p_shadow_hold;
    !commit_q |=> $stable(active_q[0][SCB_IDX_POWER]) && $stable(active_q[1][SCB_IDX_POWER]);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("active changed without commit");

  property p_commit_both;
    commit_q |=> active_q[0][SCB_IDX_POWER] == $past(master_q[0][SCB_IDX_POWER])
             && active_q[1][SCB_IDX_POWER] == $past(master_q[1][SCB_IDX_POWER]);
  endproperty
  a_commit_both: assert property (p_commit_both) else $error("commit missed a channel");

  property p_local_a_only;
    wr_pwr && chan_sel_q == 2'h1 |=> $stable(master_q[1][SCB_IDX_POWER])
                                  && master_q[0][SCB_IDX_POWER] == $past(wr_q.data);
  endproperty
  a_local_a_only: assert property (p_local_a_only) else $error("local write leaked");

  property p_local_both;
    wr_pwr && chan_sel_q == 2'h3 |=> master_q[0][SCB_IDX_POWER] == $past(wr_q.data)
                                  && master_q[1][SCB_IDX_POWER] == $past(wr_q.data);
  endproperty
  a_local_both: assert property (p_local_both) else $error("both-channel write failed");

  property p_read_a;
    instr_end && instr_d[SCB_INSTR_RW] && instr_d[SCB_ADDR_W-1:0] == SCB_ADDR_POWER
      && chan_sel_q == 2'h3 |=> shift_out_q == $past(master_q[0][SCB_IDX_POWER]);
  endproperty
  a_read_a: assert property (p_read_a) else $error("both-selected read not channel A");

  property p_global_clock;
    wr_valid_q && wr_q.addr == SCB_ADDR_CLOCK |=> clock_q[SCB_BIT_STAB] == $past(wr_q.data[0]);
  endproperty
  a_global_clock: assert property (p_global_clock) else $error("global write gated");

  property p_strap_out;
    strap_mode_q && strap_done_q |=> DUTY_CYCLE_STABILIZER == $past(strap_stab_q)
                                  && TWOS_COMPLEMENT == $past(strap_twos_q);
  endproperty
  a_strap_out: assert property (p_strap_out) else $error("strap not on outputs");

  property p_strap_ends;
    csn_fall |=> !strap_mode_q ##1 !STRAP_MODE;
  endproperty
  a_strap_ends: assert property (p_strap_ends) else $error("serial port not enabled");

  c_write_frame: cover property (wr_valid_q);
  c_read_frame: cover property (!SDIO_OE_N ##[1:200] SDIO_OE_N);
  c_commit: cover property (commit_q ##2 $changed(CHA_CFG));
  c_strap_done: cover property (strap_mode_q && strap_done_q);

endmodule

/* File: verification/scb_host.sv */
`timescale 1ns/1ps
module scb_host (
  input wire logic sys_clk,
  input wire logic sdio_out,
  input wire logic sdio_oe_n,
  output logic sclk,
  output logic chip_select_n,
  output logic sdio_in
);
  // ************************************************************
  // pin drive
  // ************************************************************
  logic drv;

  // device wins the shared pin only while it enables its driver
  assign sdio_in = sdio_oe_n ? drv : sdio_out;

  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    drv = 1'b1;
  end

  task automatic strap(input logic sck, input logic sd);
    sclk <= sck;
    drv <= sd;
  endtask

  // ************************************************************
  // one serial bit, sampled late in the clock high phase, half a cycle before it falls
  // ************************************************************
  task automatic bit_cycle(input logic b, input logic rd, output logic s, output logic oe_n);
    @(posedge sys_clk);
    sclk <= 1'b0;
    // released line toggles so a stale value never reads as valid
    drv <= rd ? ~drv : b;
    repeat (4) @(posedge sys_clk);
    sclk <= 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    s = sdio_in;
    oe_n = sdio_oe_n;
  endtask

  // w is the byte count less one; only one or two bytes are driven
  task automatic xfer(input logic rd, input logic [1:0] w, input logic [12:0] addr,
                      input logic [15:0] wd, output logic [15:0] q, output logic ok);
    logic [15:0] ins;
    logic s;
    logic oe_n;
    ins = {rd, w, addr};
    ok = 1'b1;
    q = 16'h0000;
    @(posedge sys_clk);
    chip_select_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(ins[i], 1'b0, s, oe_n);
      if (i > 0 && oe_n !== 1'b1) ok = 1'b0;
    end
    for (int i = (w[0] ? 15 : 7); i >= 0; i--) begin
      bit_cycle(wd[i], rd, s, oe_n);
      q[i] = s;
      if (oe_n !== ~rd) ok = 1'b0;
    end
    @(posedge sys_clk);
    sclk <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chip_select_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    // the device must have let go of the pin once the frame is over
    if (sdio_oe_n !== 1'b1) ok = 1'b0;
  endtask
endmodule

/* File: verification/scb_spi_config_bank_tb_top.sv */
`timescale 1ns/1ps
module scb_spi_config_bank_tb_top;
  import scb_pkg::*;
  logic SYS_CLK;
  logic SYS_RST;
  logic sclk;
  logic cs_n;
  logic sdio_in;
  logic sdio_out;
  logic sdio_oe_n;
  logic strap_mode;
  logic stab;
  logic twos;
  scb_ch_cfg_t cha_cfg;
  scb_ch_cfg_t chb_cfg;
  logic [15:0] rq;
  logic rok;
  int n_errors;
  int cmp_count;

  always #25 SYS_CLK = ~SYS_CLK;

  scb_host host (.sys_clk(SYS_CLK), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .sclk(sclk), .chip_select_n(cs_n), .sdio_in(sdio_in));

  scb_spi_config_bank DUT (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .SCLK(sclk),
    .CHIP_SELECT_N(cs_n), .SDIO_IN(sdio_in), .SDIO_OUT(sdio_out), .SDIO_OE_N(sdio_oe_n),
    .STRAP_MODE(strap_mode), .DUTY_CYCLE_STABILIZER(stab), .TWOS_COMPLEMENT(twos),
    .CHA_CFG(cha_cfg), .CHB_CFG(chb_cfg));

  // ************************************************************
  // checking and access tasks
  // ************************************************************
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, 2'h0, a, {8'h00, d}, rq, rok);
    chk("write pin direction", {7'h00, rok}, 8'h01);
  endtask

  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    host.xfer(1'b1, 2'h0, a, 16'h0000, rq, rok);
    chk("read pin direction", {7'h00, rok}, 8'h01);
    chk($sformatf("reg %h", a), rq[7:0], exp);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    SYS_CLK = 1'b0;
    SYS_RST = 1'b1;
    n_errors = 0;
    cmp_count = 0;
    host.strap(1'b1, 1'b0);
    repeat (3) @(posedge SYS_CLK);
    chk("stab in reset", {7'h00, stab}, 8'h01);
    chk("format in reset", {7'h00, twos}, 8'h00);
    chk("oe in reset", {7'h00, sdio_oe_n}, 8'h01);
    repeat (2) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    repeat (12) @(posedge SYS_CLK);
    chk("strap mode", {7'h00, strap_mode}, 8'h01);
    chk("strap stab", {7'h00, stab}, 8'h00);
    chk("strap format", {7'h00, twos}, 8'h01);
    host.strap(1'b0, 1'b1);
    rd(SCB_ADDR_CLOCK, 8'h01);
    chk("strap left", {7'h00, strap_mode}, 8'h00);
    chk("reg stab", {7'h00, stab}, 8'h01);
    chk("reg format", {7'h00, twos}, 8'h01);
    rd(SCB_ADDR_CHAN_SEL, 8'h03);
    rd(SCB_ADDR_POWER, 8'h80);
    rd(SCB_ADDR_OUT_MODE, 8'h01);
    rd(SCB_ADDR_COMMIT, 8'h00);
    rd(SCB_ADDR_PORT_CFG, SCB_RST_PORT_CFG);
    rd(SCB_ADDR_GRADE, SCB_RST_GRADE);
    // global register must ignore a partial channel selection
    wr(SCB_ADDR_CHAN_SEL, 8'h02);
    wr(SCB_ADDR_CLOCK, 8'h00);
    chk("global stab", {7'h00, stab}, 8'h00);
    wr(SCB_ADDR_CHAN_SEL, 8'h01);
    rd(SCB_ADDR_CLOCK, 8'h00);
    wr(SCB_ADDR_CHAN_SEL, 8'h03);
    wr(SCB_ADDR_POWER, 8'h82);
    wr(SCB_ADDR_OUT_MODE, 8'h00);
    wr(SCB_ADDR_FD_FIRST, 8'h00);
    chk("cha pending", {4'h0, cha_cfg}, 8'h00);
    chk("format pending", {7'h00, twos}, 8'h01);
    wr(SCB_ADDR_COMMIT, 8'h01);
    chk("cha commit", {4'h0, cha_cfg}, 8'h02);
    chk("chb commit", {4'h0, chb_cfg}, 8'h02);
    chk("format commit", {7'h00, twos}, 8'h00);
    rd(SCB_ADDR_COMMIT, 8'h00);
    wr(SCB_ADDR_CHAN_SEL, 8'h01);
    wr(SCB_ADDR_POWER, 8'h81);
    wr(SCB_ADDR_CHAN_SEL, 8'h02);
    wr(SCB_ADDR_POWER, 8'hA3);
    rd(SCB_ADDR_POWER, 8'hA3);
    wr(SCB_ADDR_CHAN_SEL, 8'h03);
    wr(SCB_ADDR_FD_FIRST, 8'h01);
    rd(SCB_ADDR_POWER, 8'h81);
    chk("cha held", {4'h0, cha_cfg}, 8'h02);
    wr(SCB_ADDR_COMMIT, 8'h01);
    chk("cha local", {4'h0, cha_cfg}, 8'h09);
    chk("chb local", {4'h0, chb_cfg}, 8'h0F);
    // two-byte frames walk the address up by one per byte
    host.xfer(1'b0, 2'h1, SCB_ADDR_POWER, 16'h8001, rq, rok);
    chk("two byte write pin", {7'h00, rok}, 8'h01);
    chk("two byte clock", {7'h00, stab}, 8'h01);
    chk("cha still held", {4'h0, cha_cfg}, 8'h09);
    host.xfer(1'b1, 2'h1, SCB_ADDR_POWER, 16'h0000, rq, rok);
    chk("two byte read pin", {7'h00, rok}, 8'h01);
    chk("two byte first", rq[15:8], 8'h80);
    chk("two byte second", rq[7:0], 8'h01);
    // mid-run reset must bring the defaults back
    SYS_RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    repeat (12) @(posedge SYS_CLK);
    chk("cha after reset", {4'h0, cha_cfg}, 8'h00);
    rd(SCB_ADDR_CLOCK, 8'h01);
    rd(SCB_ADDR_POWER, 8'h80);
    rd(SCB_ADDR_CHAN_SEL, 8'h03);
    test_done();
  end

  initial begin
    repeat (100000) @(posedge SYS_CLK);
    n_errors++;
    $display("ERROR run time expected end seen none");
    test_done();
  end
endmodule
